// ===== rtl/ebp_bridge.v
// How it works
// [RULE1] Up to four outputs, driven per arrangement.
// [RULE2] Software selects mode and direction bits first.
// [RULE3] PWM outputs override shared port function.
// [RULE4] Single arrangement equals standard one-line PWM.
// [RULE5] Output active level selectable per mode field.
// [RULE6] Controls shadowed, loaded at period start.
// [RULE7] Delay loads at duty or period end.
// [RULE8] Enhanced waveform starts one instruction cycle late; the code holds it off until the first period end.
// [RULE9] Four arrangements: single, half, forward, reverse.
// [RULE10] Period is 4 Tosc times (period+1) times prescale.
// [RULE11] Duty is Tosc times ten-bit duty times prescale.
// [RULE12] Dead band is 4 Tosc times seven-bit count.
// [RULE13] Half bridge: A carries PWM, B complement.
// [RULE14] Half bridge legs delayed; long delay keeps inactive.
// [RULE15] Software makes C2 and D5 outputs.
// [RULE16] Full bridge: forward A on/D mod; reverse C on/B mod.
// [RULE17] Software makes C2 and D5-D7 outputs.
// [RULE18] New direction applies from next period.
// [RULE19] Direction change: modulated off, unmodulated swap early.
// [RULE20] Direction may be written anytime in cycle.
// [RULE21] Full bridge inserts no dead band.
// [RULE22] Software lowers duty before reversing near full.
// [RULE23] Arrangement codes: 00 single,01 fwd,10 half,11 rev.
// [RULE24] Mode bit1 inverts A/C, bit0 inverts B/D.
// [RULE25] Dead band delays only inactive-to-active transitions.
// [RULE26] Polarity applied after steering and delay.
// [RULE27] Period boundary is timer match-and-reset cycle.
//
// Top of the bridge PWM steering block with its APB register slave.
// Assumes clk is the oscillator clock; pins are three-signal ports resolved outside.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`include "ebp_map.vh"
module ebp_bridge
(
   input  wire        clk,
   input  wire        arst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [3:0]  pin_in,
   output wire [3:0]  pin_out,
   output wire [3:0]  pin_oe
);
   // Shadow copies and port registers written by software.
   reg  [7:0]  unit_control_ff;
   reg  [7:0]  pwm_config_ff;
   reg  [7:0]  duty_high_byte_ff;
   reg  [7:0]  period_register_ff;
   reg  [1:0]  timer_prescale_select_ff;
   reg  [3:0]  port_data_ff;
   reg  [3:0]  port_dir_ff;
   // Working copies loaded at boundaries.
   reg  [1:0]  w_arr_ff;
   reg  [3:0]  w_mode_ff;
   reg  [9:0]  w_duty_ff;
   reg  [7:0]  w_period_ff;
   reg  [1:0]  w_ps_ff;
   reg  [6:0]  w_delay_ff;
   reg         started_ff;
   reg         duty_on_ff;
   reg  [3:0]  act_ff;
   reg  [3:0]  pwm_pin_ff;
   reg  [3:0]  nxt_act;
   wire        pwm_mode;
   wire        period_end;
   wire        tcy_tick;
   wire        last_tcy;
   wire [9:0]  phase;
   wire        duty_act;
   wire        duty_end;
   wire        dir_change;
   wire        raw_b;
   wire        leg_a;
   wire        leg_b;
   wire [3:0]  pol;
   wire [3:0]  pwm_owns;
   wire        wr_en;
   wire [7:0]  wbyte;

   // Mode field upper bits 11 select the PWM family.
   function is_pwm;
      input [3:0] mode;
      begin
         is_pwm = (mode[`EBP_MODE_PWM_HI:`EBP_MODE_PWM_LO] == `EBP_MODE_PWM);
      end
   endfunction

   // Full-bridge codes are the two with the low arrangement bit set.
   function is_full;
      input [1:0] arr;
      begin
         is_full = (arr == `EBP_ARR_FWD) || (arr == `EBP_ARR_REV);
      end
   endfunction

   // Bus slave: zero wait states, every access answered in its access phase.
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel && penable && pwrite;
   assign wbyte   = pwdata[7:0];

   // Register writes land in the shadow copies; direction may change anytime.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         unit_control_ff          <= `EBP_CTRL_RST;
         pwm_config_ff            <= `EBP_CFG_RST;
         duty_high_byte_ff        <= `EBP_DUTY_RST;
         period_register_ff       <= `EBP_PERIOD_RST;
         timer_prescale_select_ff <= `EBP_PS_RST;
         port_data_ff             <= 4'h0;
         port_dir_ff              <= `EBP_DIR_RST;
      end
      else if (wr_en)
      begin
         case (paddr)
            `EBP_UNIT_CONTROL_ADDR: unit_control_ff <= wbyte;   // [RULE20]
            `EBP_PWM_CONFIG_ADDR:   pwm_config_ff <= wbyte;
            `EBP_DUTY_HIGH_ADDR:    duty_high_byte_ff <= wbyte;
            `EBP_PERIOD_ADDR:       period_register_ff <= wbyte;
            `EBP_PRESCALE_ADDR:     timer_prescale_select_ff <= wbyte[1:0];
            `EBP_PORT_DATA_ADDR:    port_data_ff <= wbyte[3:0];
            `EBP_PORT_DIR_ADDR:     port_dir_ff <= wbyte[3:0];
            default:                port_dir_ff <= port_dir_ff;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero.
   always @*
   begin
      case (paddr)
         `EBP_UNIT_CONTROL_ADDR: prdata = {24'h000000, unit_control_ff};
         `EBP_PWM_CONFIG_ADDR:   prdata = {24'h000000, pwm_config_ff};
         `EBP_DUTY_HIGH_ADDR:    prdata = {24'h000000, duty_high_byte_ff};
         `EBP_PERIOD_ADDR:       prdata = {24'h000000, period_register_ff};
         `EBP_PRESCALE_ADDR:     prdata = {30'h0, timer_prescale_select_ff};
         `EBP_PORT_DATA_ADDR:    prdata = {28'h0000000, pin_in};
         `EBP_PORT_DIR_ADDR:     prdata = {28'h0000000, port_dir_ff};
         // Steering is shown before its register; it matches the working arrangement except during an early swap.
         `EBP_STATUS_ADDR:       prdata = {18'h0, duty_on_ff, started_ff, nxt_act, w_arr_ff,
                                           2'h0, w_mode_ff};
         default:                prdata = 32'h00000000;
      endcase
   end

   assign pwm_mode = is_pwm(unit_control_ff[`EBP_MODE_HI:`EBP_MODE_LO]);

   // Timer runs on the working period and prescale once the unit is in PWM mode.
   ebp_timebase u_timebase
   (
      .clk          (clk),
      .arst_n       (arst_n),
      .run          (pwm_mode),
      .period_val   (w_period_ff),
      .prescale_sel (w_ps_ff),
      .period_end   (period_end),                               // [RULE10] [RULE27]
      .tcy_tick     (tcy_tick),
      .last_tcy     (last_tcy),
      .phase        (phase)
   );

   // Active while the phase is below the ten-bit duty; compared live so the width is exact.
   assign duty_act   = started_ff && (phase < w_duty_ff);      // [RULE11]
   // The duty boundary is the first cycle after the active time has ended.
   assign duty_end   = duty_on_ff && !duty_act;
   assign dir_change = is_full(w_arr_ff) && is_full(unit_control_ff[`EBP_ARR_HI:`EBP_ARR_LO])
                       && (w_arr_ff != unit_control_ff[`EBP_ARR_HI:`EBP_ARR_LO]);

   // Shadow to working transfer happens on the boundary cycle; mode, period and prescale also copy every cycle while PWM mode is off.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         w_arr_ff    <= `EBP_ARR_SINGLE;
         w_mode_ff   <= 4'h0;
         w_duty_ff   <= 10'h000;
         w_period_ff <= `EBP_PERIOD_RST;
         w_ps_ff     <= `EBP_PS_RST;
         w_delay_ff  <= 7'h00;
         started_ff  <= 1'b0;
         duty_on_ff  <= 1'b0;
      end
      else if (!pwm_mode)
      begin
         w_mode_ff   <= unit_control_ff[`EBP_MODE_HI:`EBP_MODE_LO];
         w_period_ff <= period_register_ff;
         w_ps_ff     <= timer_prescale_select_ff;
         started_ff  <= 1'b0;
         duty_on_ff  <= 1'b0;
      end
      else
      begin
         if (period_end)
         begin
            w_arr_ff    <= unit_control_ff[`EBP_ARR_HI:`EBP_ARR_LO];   // [RULE6] [RULE18]
            w_mode_ff   <= unit_control_ff[`EBP_MODE_HI:`EBP_MODE_LO];
            w_duty_ff   <= {duty_high_byte_ff,
                            unit_control_ff[`EBP_DUTY_LOW_HI:`EBP_DUTY_LOW_LO]};
            w_period_ff <= period_register_ff;
            w_ps_ff     <= timer_prescale_select_ff;
            started_ff  <= 1'b1;                                   // [RULE8]
         end
         duty_on_ff <= duty_act;
         // The delay count loads at every duty boundary and every period boundary.
         if (period_end || duty_end)
            w_delay_ff <= pwm_config_ff[`EBP_DEL_HI:`EBP_DEL_LO];  // [RULE7]
      end
   end

   // Half-bridge legs: A follows duty, B its complement, each with dead band.
   assign raw_b = started_ff && !duty_act;                         // [RULE13]

   ebp_deadband u_leg_a
   (
      .clk         (clk),
      .arst_n      (arst_n),
      .raw_active  (duty_act),
      .tcy_tick    (tcy_tick),
      .delay_count (w_delay_ff),
      .out_active  (leg_a)                                         // [RULE14] [RULE25]
   );

   ebp_deadband u_leg_b
   (
      .clk         (clk),
      .arst_n      (arst_n),
      .raw_active  (raw_b),
      .tcy_tick    (tcy_tick),
      .delay_count (w_delay_ff),
      .out_active  (leg_b)                                         // [RULE12] [RULE14]
   );

   // Steering per arrangement; bit order is {d, c, b, a}.
   always @*
   begin
      nxt_act = 4'h0;
      case (w_arr_ff)                                              // [RULE9] [RULE23]
         `EBP_ARR_SINGLE: nxt_act = {3'h0, duty_act};              // [RULE4]
         `EBP_ARR_HALF:   nxt_act = {2'h0, leg_b, leg_a};
         `EBP_ARR_FWD:    nxt_act = {duty_act, 2'h0, 1'b1};        // [RULE16] [RULE21]
         `EBP_ARR_REV:    nxt_act = {1'b0, 1'b1, duty_act, 1'b0};
         default:         nxt_act = 4'h0;
      endcase
      // Early swap before the boundary on a pending reversal; modulated legs held off.
      if (dir_change && last_tcy)                                  // [RULE19]
         nxt_act = (unit_control_ff[`EBP_ARR_HI:`EBP_ARR_LO] == `EBP_ARR_FWD) ? 4'h1 : 4'h4;
      if (!started_ff)
         nxt_act = 4'h0;
   end

   // Outputs registered so pins never see combinational hazards.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         act_ff     <= 4'h0;
         pwm_pin_ff <= 4'h0;
      end
      else
      begin
         act_ff     <= nxt_act;
         pwm_pin_ff <= nxt_act ^ pol;                              // [RULE5] [RULE26]
      end
   end

   // Polarity per pair from the working mode low bits.
   assign pol = {w_mode_ff[`EBP_POL_BD_BIT], w_mode_ff[`EBP_POL_AC_BIT],
                 w_mode_ff[`EBP_POL_BD_BIT], w_mode_ff[`EBP_POL_AC_BIT]};   // [RULE24]

   // Pins the PWM owns: A always in PWM mode, B when dual or quad, C and D when quad.
   assign pwm_owns = !is_pwm(w_mode_ff) ? 4'h0 :
                     is_full(w_arr_ff) ? 4'hF :
                     (w_arr_ff == `EBP_ARR_HALF) ? 4'h3 : 4'h1;   // [RULE1] [RULE3]

   // Direction bits (1 = input) still gate the pin; PWM takes the data path.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_pin
         assign pin_out[gi] = pwm_owns[gi] ? pwm_pin_ff[gi] : port_data_ff[gi];
         assign pin_oe[gi]  = !port_dir_ff[gi];                    // [RULE2]
      end
   endgenerate
endmodule // ebp_bridge

// ===== rtl/ebp_map.vh
// Register map, field positions, encodings and timing constants of the bridge PWM steering block.
// Assumes inclusion by bare name from the rtl directory.
`ifndef EBP_MAP_VH
`define EBP_MAP_VH
// APB register byte addresses.
`define EBP_UNIT_CONTROL_ADDR   12'h000
`define EBP_PWM_CONFIG_ADDR     12'h004
`define EBP_DUTY_HIGH_ADDR      12'h008
`define EBP_PERIOD_ADDR         12'h00C
`define EBP_PRESCALE_ADDR       12'h010
`define EBP_PORT_DATA_ADDR      12'h014
`define EBP_PORT_DIR_ADDR       12'h018
`define EBP_STATUS_ADDR         12'h01C
// Unit control and PWM config field positions.
`define EBP_ARR_HI              7
`define EBP_ARR_LO              6
`define EBP_DUTY_LOW_HI         5
`define EBP_DUTY_LOW_LO         4
`define EBP_MODE_HI             3
`define EBP_MODE_LO             0
`define EBP_MODE_PWM_HI         3
`define EBP_MODE_PWM_LO         2
`define EBP_POL_AC_BIT          1
`define EBP_POL_BD_BIT          0
`define EBP_DEL_HI              6
`define EBP_DEL_LO              0
// Encodings.
`define EBP_MODE_PWM            2'h3
`define EBP_ARR_SINGLE          2'h0
`define EBP_ARR_FWD             2'h1
`define EBP_ARR_HALF            2'h2
`define EBP_ARR_REV             2'h3
`define EBP_PS_1                2'h0
`define EBP_PS_4                2'h1
// Reset values.
`define EBP_CTRL_RST            8'h00
`define EBP_CFG_RST             8'h00
`define EBP_DUTY_RST            8'h00
`define EBP_PERIOD_RST          8'hFF
`define EBP_PS_RST              2'h0
`define EBP_DIR_RST             4'hF
// Clock cycles per instruction cycle (4 oscillator periods).
`define EBP_TCY_CLKS            4
`define EBP_TCY_CNT_MAX         2'h3
`endif

// ===== rtl/ebp_timebase.v
// Period timer with prescaler: emits the period boundary and the ten-bit duty phase.
// Assumes one clk is one oscillator period; settings are the working copies from the top.
`timescale 1ns/10ps
`include "ebp_map.vh"
module ebp_timebase
(
   input  wire        clk,
   input  wire        arst_n,
   input  wire        run,
   input  wire [7:0]  period_val,
   input  wire [1:0]  prescale_sel,
   output wire        period_end,
   output wire        tcy_tick,
   output wire        last_tcy,
   output wire [9:0]  phase
);
   reg  [3:0]  ps_ff;
   reg  [1:0]  q_ff;
   reg  [7:0]  tmr_ff;
   wire [3:0]  ps_max;
   wire        ps_wrap;
   wire        tick;

   // Prescale wrap value: 1, 4 or 16 clocks per quarter step.
   assign ps_max   = (prescale_sel == `EBP_PS_1) ? 4'h0 :
                     (prescale_sel == `EBP_PS_4) ? 4'h3 : 4'hF;
   assign ps_wrap  = (ps_ff == ps_max);
   assign tick     = ps_wrap && (q_ff == `EBP_TCY_CNT_MAX);
   // One pulse per four clocks whatever the prescale, so dead band stays in instruction cycles.
   // The prescaler restarts at every phase step, which keeps the pulse aligned to boundaries.
   assign tcy_tick = run && ((prescale_sel == `EBP_PS_1) ? (q_ff == `EBP_TCY_CNT_MAX) :
                                                           (ps_ff[1:0] == `EBP_TCY_CNT_MAX));
   // The period ends when the timer matches the period value and resets.
   assign period_end = run && tick && (tmr_ff == period_val);
   // The last timer count spans one instruction cycle times prescale before the boundary.
   assign last_tcy   = run && (tmr_ff == period_val);
   // Phase counts oscillator periods at the prescaled rate: timer plus quarter.
   assign phase      = {tmr_ff, q_ff};

   // Quarter counter, prescaler and timer advance together.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ps_ff  <= 4'h0;
         q_ff   <= 2'h0;
         tmr_ff <= 8'h00;
      end
      else if (!run)
      begin
         ps_ff  <= 4'h0;
         q_ff   <= 2'h0;
         tmr_ff <= 8'h00;
      end
      else
      begin
         ps_ff <= ps_wrap ? 4'h0 : ps_ff + 4'h1;
         if (ps_wrap)
            q_ff <= q_ff + 2'h1;
         if (tick)
            tmr_ff <= (tmr_ff == period_val) ? 8'h00 : tmr_ff + 8'h01;
      end
   end
endmodule // ebp_timebase

// ===== rtl/ebp_deadband.v
// Dead band delay on one half-bridge leg: delays inactive-to-active edges only.
// Assumes tcy_tick pulses once per instruction cycle.
`timescale 1ns/10ps
`include "ebp_map.vh"
module ebp_deadband
(
   input  wire        clk,
   input  wire        arst_n,
   input  wire        raw_active,
   input  wire        tcy_tick,
   input  wire [6:0]  delay_count,
   output wire        out_active
);
   reg  [6:0]  cnt_ff;
   reg         act_ff;

   // Release falls at once; rising waits out the count in instruction cycles.
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_ff <= 7'h00;
         act_ff <= 1'b0;
      end
      else if (!raw_active)
      begin
         cnt_ff <= 7'h00;
         act_ff <= 1'b0;
      end
      else if (!act_ff)
      begin
         if (cnt_ff >= delay_count)
            act_ff <= 1'b1;
         else if (tcy_tick)
            cnt_ff <= cnt_ff + 7'h01;
      end
   end

   // The leg rises in the cycle the count is reached, so a zero count adds no delay.
   // A count longer than the active time never reaches its end, so the leg stays off.
   assign out_active = raw_active && (act_ff || (cnt_ff >= delay_count));
endmodule // ebp_deadband

// ===== verification/ebp_bridge_assertions.sv
// Checker for the bridge PWM steering block, seeing only its top ports.
// Assumes zero-wait APB and the status word layout of the register map.
`timescale 1ns/10ps
`include "ebp_map.vh"
module ebp_bridge_assertions
(
   input wire        clk,
   input wire        arst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [3:0]  pin_in,
   input wire [3:0]  pin_out,
   input wire [3:0]  pin_oe
);
   // Status reads show pin activity before polarity, so steering is visible.
   wire rd = psel && penable && !pwrite;
   wire st = rd && paddr == `EBP_STATUS_ADDR;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_dir_wr;
      psel && penable && pwrite && paddr == `EBP_PORT_DIR_ADDR;
   endsequence
   property p_oe_wr;
      s_dir_wr |=> pin_oe == ~$past(pwdata[3:0]);
   endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("oe not set by dir write");
   property p_dir_rd;
      rd && paddr == `EBP_PORT_DIR_ADDR |-> prdata[3:0] == ~pin_oe;
   endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("dir readback wrong");
   property p_pin_rd;
      rd && paddr == `EBP_PORT_DATA_ADDR |-> prdata[3:0] == pin_in;
   endproperty
   a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong");
   property p_rdy;
      psel && penable |-> pready && !pslverr;
   endproperty
   a_rdy: assert property (p_rdy) else $error("wait state or error");
   property p_unmap;
      rd && paddr >= 12'h020 |-> prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_single;
      st && prdata[7:6] == `EBP_ARR_SINGLE |-> prdata[11:9] == 3'h0;
   endproperty
   a_single: assert property (p_single) else $error("single drives extra");
   property p_half;
      st && prdata[7:6] == `EBP_ARR_HALF |-> prdata[11:10] == 2'h0 && !(prdata[8] && prdata[9]);
   endproperty
   a_half: assert property (p_half) else $error("half overlap");
   property p_fwd;
      st && prdata[7:6] == `EBP_ARR_FWD |-> !prdata[9] && !(prdata[8] && prdata[10]);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward drives b or c");
   property p_rev;
      st && prdata[7:6] == `EBP_ARR_REV |-> !prdata[11] && !(prdata[8] && prdata[10]);
   endproperty
   a_rev: assert property (p_rev) else $error("reverse drives a or d");
endmodule // ebp_bridge_assertions
bind ebp_bridge ebp_bridge_assertions u_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== verification/ebp_switch_model.sv
// Bridge switch driver inputs seen as the four pin lines.
// Assumes pull-downs on every line, holding the switches off when undriven.
`timescale 1ns/10ps
module ebp_switch_model
(
   input  wire [3:0] pin_out,
   input  wire [3:0] pin_oe,
   output wire [3:0] pin_level
);
   // A released line falls to its pull-down rather than keeping its last value.
   assign pin_level = pin_out & pin_oe;
endmodule // ebp_switch_model

// ===== verification/tb_enhanced_bridge_pwm_steering.sv
// Self-checking bench for the bridge PWM steering block.
// Assumes the switch model resolves the pins and the checker is bound.
`timescale 1ns/10ps
`include "ebp_map.vh"
module tb_enhanced_bridge_pwm_steering;
   reg         clk, arst_n, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   wire [31:0] prdata;
   wire        pready, pslverr;
   wire [3:0]  pin_in, pin_out, pin_oe;
   integer     fail_count, n_compared, cyc, k, m;
   reg  [31:0] cnt [0:3];
   ebp_bridge uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   ebp_switch_model u_sw (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task close_out;
   begin
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   // A hang is cut short well past the few thousand cycles the run needs.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count = fail_count + 1;
         close_out;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task apb(input w, input [11:0] a, input [7:0] d);
   begin
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   // Settles three windows, then counts high cycles of each pin over one period.
   task meas(input [31:0] win, input [31:0] a, input [31:0] b, input [31:0] c,
             input [31:0] d);
   begin
      repeat (3 * win) @(posedge clk);
      for (k = 0; k < 4; k = k + 1)
         cnt[k] = 0;
      repeat (win)
      begin
         @(posedge clk);
         for (k = 0; k < 4; k = k + 1)
            cnt[k] = cnt[k] + pin_in[k];
      end
      chk(cnt[0], a);
      chk(cnt[1], b);
      chk(cnt[2], c);
      chk(cnt[3], d);
   end
   endtask
   task t_reset;
   begin
      apb(1'b0, `EBP_PERIOD_ADDR, 8'h00);
      chk(rd[7:0], 8'hFF);
      apb(1'b0, `EBP_PORT_DIR_ADDR, 8'h00);
      chk(rd[3:0], 4'hF);
      apb(1'b0, `EBP_UNIT_CONTROL_ADDR, 8'h00);
      chk(rd[7:0], 8'h00);
      apb(1'b0, 12'h020, 8'h00);
      chk(rd, 32'h0);
   end
   endtask
   task t_shadow;
   begin
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'h8C);
      apb(1'b0, `EBP_STATUS_ADDR, 8'h00);
      chk(rd[7:6], 2'h0);
      repeat (1100) @(posedge clk);
      apb(1'b0, `EBP_STATUS_ADDR, 8'h00);
      chk(rd[7:6], 2'h2);
   end
   endtask
   // Period 4*(3+1)*ps clocks, duty 8*ps clocks; b and d follow the port latch.
   task t_single;
   begin
      // Mode off first, so the new period loads at once instead of at the long old boundary.
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'h00);
      apb(1'b1, `EBP_PERIOD_ADDR, 8'h03);
      apb(1'b1, `EBP_DUTY_HIGH_ADDR, 8'h02);
      apb(1'b1, `EBP_PORT_DATA_ADDR, 8'h0A);
      apb(1'b1, `EBP_PORT_DIR_ADDR, 8'h00);
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'h0C);
      meas(16, 8, 16, 0, 16);
      apb(1'b1, `EBP_PRESCALE_ADDR, 8'h01);
      meas(64, 32, 64, 0, 64);
      apb(1'b1, `EBP_PRESCALE_ADDR, 8'h00);
      repeat (64) @(posedge clk);
   end
   endtask
   task t_half;
   begin
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'h8C);
      meas(16, 8, 8, 0, 16);
      apb(1'b1, `EBP_PWM_CONFIG_ADDR, 8'h05);
      meas(16, 0, 0, 0, 16);
      apb(1'b1, `EBP_PWM_CONFIG_ADDR, 8'h01);
      meas(16, 4, 4, 0, 16);
      apb(1'b1, `EBP_PWM_CONFIG_ADDR, 8'h00);
   end
   endtask
   task t_full;
   begin
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'h4C);
      meas(16, 16, 0, 0, 8);
      apb(1'b0, `EBP_STATUS_ADDR, 8'h00);
      chk(rd[7:6], `EBP_ARR_FWD);
      for (m = 0; m < 4; m = m + 1)
      begin
         apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'hCC | m[1:0]);
         meas(16, m[1] ? 16 : 0, 8, m[1] ? 0 : 16, m[0] ? 16 : 0);
         apb(1'b0, `EBP_STATUS_ADDR, 8'h00);
         chk(rd[7:6], `EBP_ARR_REV);
      end
      // Reverse to forward, written early in a period: A alone for one instruction cycle.
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'hCC);
      repeat (64) @(posedge clk);
      @(posedge clk);
      while (pin_in[1] !== 1'b0)
         @(posedge clk);
      while (pin_in[1] !== 1'b1)
         @(posedge clk);
      apb(1'b1, `EBP_UNIT_CONTROL_ADDR, 8'h4C);
      @(posedge clk);
      while (pin_in[0] !== 1'b1)
         @(posedge clk);
      chk(pin_in, 4'h1);
      repeat (3)
      begin
         @(posedge clk);
         chk(pin_in, 4'h1);
      end
      @(posedge clk);
      chk(pin_in, 4'h9);
   end
   endtask
   initial
   begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = 0;
      fail_count = 0;
      n_compared = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_shadow;
      t_single;
      t_half;
      t_full;
      close_out;
   end
endmodule // tb_enhanced_bridge_pwm_steering
